// [design/port_compare_wake_logic.sv]
// Summary of operation
// - port3 select bits 3:0 enable pins 0..3 as wake sources
// - with no reference latched, a selected pin at zero wakes
// - once selected, each port data read or write latches the reference
// - with reference latched, a selected pin differing from it wakes
// - status bits 3:2 show port3 reference: 00 none, 01 read, 10 write
// - software writing 00 to the field restores zero-level triggering, unless a port data access in the same cycle latches a new reference
// - irq enable bit 4 forwards wake events to group-1 interrupt
// - select and status keep contents across a stop-mode recovery
//
// Our own choice: the strobed register port.
`default_nettype none
module port_compare_wake_logic (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [3:0] port3_pins,
  input wire logic [3:0] port2_pins,
  input wire wake_pkg::port_access_t port3_data_register,
  input wire wake_pkg::port_access_t port2_data_register,
  input wire logic port3_mode_bit1,
  output logic stop_wake_event,
  output logic interrupt_request_group1,
  output logic irq
);
  import wake_pkg::*;
  bus_req_t req;
  logic [3:0] port3_wake_source_select;
  logic [3:0] next_p3_select;
  logic [3:0] port2_wake_source_select;
  logic [3:0] next_p2_select;
  logic irq_enable;
  logic next_irq_enable;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic [7:0] next_rdata;
  logic next_wake_event;
  logic next_group1;
  logic [1:0] p3_source;
  logic [1:0] p2_source;
  logic p3_wake;
  logic p2_wake;
  logic p3_clear;
  logic p2_clear;
  logic [1:0] irq_status;
  logic irq_level;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic hit(input bus_req_t r, input logic [11:0] off);
    hit = (r.addr == off);
  endfunction

  assign p3_clear = req.wr && hit(req, status_offset) &&
    (req.wdata[3:2] == ref_none);
  assign p2_clear = req.wr && hit(req, status_offset) &&
    (req.wdata[1:0] == ref_none);

  pin_compare p3_cmp (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins(port3_pins),
    .select(port3_wake_source_select),
    .access(port3_data_register),
    .status_clear(p3_clear),
    .source(p3_source),
    .wake(p3_wake)
  );

  pin_compare p2_cmp (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins(port2_pins),
    .select(port2_wake_source_select),
    .access(port2_data_register),
    .status_clear(p2_clear),
    .source(p2_source),
    .wake(p2_wake)
  );

  wake_irq irq_block (
    .clk(clk),
    .sys_rst(sys_rst),
    .events({p2_wake, p3_wake}),
    .clear_wr(req.wr && hit(req, irq_status_offset)),
    .clear_bits(req.wdata[1:0]),
    .mask(irq_mask),
    .status(irq_status),
    .irq(irq_level)
  );

  always_comb begin
    next_p3_select = port3_wake_source_select;
    next_p2_select = port2_wake_source_select;
    next_irq_enable = irq_enable;
    next_irq_mask = irq_mask;
    next_rdata = 8'h00;
    if (req.wr) begin
      if (hit(req, select_offset)) begin
        next_p3_select = req.wdata[3:0];
      end
      if (hit(req, port2_select_offset)) begin
        next_p2_select = req.wdata[3:0];
      end
      if (hit(req, status_offset)) begin
        next_irq_enable = req.wdata[irq_en_bit];
      end
      if (hit(req, irq_mask_offset)) begin
        next_irq_mask = req.wdata[1:0];
      end
    end
    if (req.rd) begin
      case (req.addr)
        status_offset: next_rdata = {3'h0, irq_enable,
          p3_source, p2_source};
        irq_status_offset: next_rdata = {6'h00, irq_status};
        irq_mask_offset: next_rdata = {6'h00, irq_mask};
        default: next_rdata = 8'h00;
      endcase
    end
    next_wake_event = p3_wake | p2_wake;
    next_group1 = next_wake_event && (irq_enable || port3_mode_bit1);
  end

  // only sys_rst clears; stop recovery is no reset here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port3_wake_source_select <= select_reset;
      port2_wake_source_select <= select_reset;
      irq_enable <= 1'b0;
      irq_mask <= 2'h0;
      rdata <= 8'h00;
      stop_wake_event <= 1'b0;
      interrupt_request_group1 <= 1'b0;
      irq <= 1'b0;
    end else begin
      port3_wake_source_select <= next_p3_select;
      port2_wake_source_select <= next_p2_select;
      irq_enable <= next_irq_enable;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      stop_wake_event <= next_wake_event;
      interrupt_request_group1 <= next_group1;
      irq <= irq_level;
    end
  end
endmodule // port_compare_wake_logic
`default_nettype wire

// [design/wake_pkg.sv]
`default_nettype none
package wake_pkg;
  localparam logic [11:0] status_offset = 12'hf0a;
  localparam logic [11:0] select_offset = 12'hf0e;
  localparam logic [11:0] port2_select_offset = 12'hf0b;
  localparam logic [11:0] irq_status_offset = 12'hf20;
  localparam logic [11:0] irq_mask_offset = 12'hf21;
  localparam int irq_en_bit = 4;
  localparam int p3_status_lo = 2;
  localparam int p2_status_lo = 0;
  localparam logic [1:0] ref_none = 2'h0;
  localparam logic [1:0] ref_read = 2'h1;
  localparam logic [1:0] ref_write = 2'h2;
  localparam logic [3:0] select_reset = 4'h0;
  localparam logic [4:0] status_reset = 5'h00;
  localparam logic [1:0] event_p3 = 2'h1;
  localparam logic [1:0] event_p2 = 2'h2;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [3:0] data;
    logic rd;
    logic wr;
  } port_access_t;

  typedef enum logic [2:0] {
    src_none = 3'h1,
    src_read = 3'h2,
    src_write = 3'h4
  } ref_state_t;
endpackage
`default_nettype wire

// [design/pin_compare.sv]
`default_nettype none
module pin_compare (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] pins,
  input wire logic [3:0] select,
  input wire wake_pkg::port_access_t access,
  input wire logic status_clear,
  output logic [1:0] source,
  output logic wake
);
  import wake_pkg::*;
  ref_state_t state;
  ref_state_t next_state;
  logic [3:0] ref_bits;
  logic [3:0] next_ref_bits;
  logic next_wake;

  always_comb begin
    next_state = state;
    next_ref_bits = ref_bits;
    if (status_clear) begin
      next_state = src_none;
    end
    if (|select && access.rd) begin
      next_state = src_read;
      next_ref_bits = access.data;
    end else if (|select && access.wr) begin
      next_state = src_write;
      next_ref_bits = access.data;
    end
    if (state == src_none) begin
      next_wake = |(select & ~pins);
    end else begin
      next_wake = |(select & (pins ^ ref_bits));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= src_none;
      ref_bits <= 4'h0;
      wake <= 1'b0;
    end else begin
      state <= next_state;
      ref_bits <= next_ref_bits;
      wake <= next_wake;
    end
  end

  always_comb begin
    case (state)
      src_read: source = ref_read;
      src_write: source = ref_write;
      default: source = ref_none;
    endcase
  end
endmodule // pin_compare
`default_nettype wire

// [design/wake_irq.sv]
`default_nettype none
module wake_irq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] events,
  input wire logic clear_wr,
  input wire logic [1:0] clear_bits,
  input wire logic [1:0] mask,
  output logic [1:0] status,
  output logic irq
);
  import wake_pkg::*;
  logic [1:0] next_status;
  logic next_irq;

  always_comb begin
    next_status = status;
    if (clear_wr) begin
      next_status = status & ~clear_bits;
    end
    next_status = next_status | events;
    next_irq = |(next_status & mask);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status <= 2'h0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= next_irq;
    end
  end
endmodule // wake_irq
`default_nettype wire

// [bench/pins_model.sv]
`default_nettype none
module pins_model (
  input wire logic clk,
  input wire logic [3:0] lv3,
  input wire logic [3:0] lv2,
  output logic [3:0] port3_pins,
  output logic [3:0] port2_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // pin levels move just after an edge
  always_ff @(posedge clk) begin
    port3_pins <= lv3;
    port2_pins <= lv2;
  end
endmodule // pins_model
`default_nettype wire

// [bench/wake_chk.sv]
`default_nettype none
module wake_chk import wake_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [3:0] port3_pins,
  input wire wake_pkg::port_access_t port3_data_register,
  input wire logic port3_mode_bit1,
  input wire logic stop_wake_event,
  input wire logic interrupt_request_group1
);
  import wake_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] s3;
  logic [3:0] s2;
  logic nr;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s3 <= 4'h0;
      s2 <= 4'h0;
      nr <= 1'b1;
    end else begin
      if (wr && addr == select_offset) s3 <= wdata[3:0];
      if (wr && addr == port2_select_offset) s2 <= wdata[3:0];
      if (s3 != 0 && (port3_data_register.rd || port3_data_register.wr))
        nr <= 1'b0;
      else if (wr && addr == status_offset && wdata[3:2] == 2'h0)
        nr <= 1'b1;
    end
  end
  sequence p3_acc(b);
    s3 != 0 && b && !wr ##[1:2] rd && addr == status_offset;
  endsequence
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  a_rsvd_zero: assert property (rd && addr == status_offset |=>
    rdata[7:5] == 3'h0) else $error("status top bits set");
  a_src_read: assert property (p3_acc(port3_data_register.rd) |=>
    rdata[3:2] == ref_read) else $error("read ref not shown");
  a_src_write: assert property (p3_acc(port3_data_register.wr) |=>
    rdata[3:2] == ref_write) else $error("write ref not shown");
  a_irq_gate: assert property (interrupt_request_group1 |->
    stop_wake_event) else $error("irq without wake");
  a_mode_fwd: assert property (port3_mode_bit1 && $past(port3_mode_bit1)
    |-> interrupt_request_group1 == stop_wake_event) else $error("mode fwd");
  a_no_select: assert property ((s3 == 0 && s2 == 0)[*4] |->
    !stop_wake_event) else $error("wake unselected");
  a_zero_wake: assert property ((nr && (s3 & ~port3_pins) != 0)[*4]
    |-> stop_wake_event) else $error("zero pin no wake");
endmodule // wake_chk
bind port_compare_wake_logic wake_chk chk (.*);
`default_nettype wire

// [bench/tb_top.sv]
`default_nettype none
module tb_top;
  import wake_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, wr, rd, mode, wake, g1, irq;
  logic [11:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] lv3, lv2, p3, p2;
  port_access_t a3, a2;
  int num_errors = 0;
  int num_checks = 0;
  port_compare_wake_logic dut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port3_pins(p3),
    .port2_pins(p2), .port3_data_register(a3), .port2_data_register(a2),
    .port3_mode_bit1(mode), .stop_wake_event(wake),
    .interrupt_request_group1(g1), .irq(irq));
  pins_model pm (.clk(clk), .lv3(lv3), .lv2(lv2), .port3_pins(p3),
    .port2_pins(p2));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(rdata, e);
  endtask
  task automatic pacc(input logic two, input logic w, input logic [3:0] d);
    @(posedge clk) if (two) a2 <= '{d, !w, w}; else a3 <= '{d, !w, w};
    @(posedge clk) begin a2 <= '0; a3 <= '0; end
  endtask
  task automatic wk(input logic [2:0] e);
    repeat (6) @(negedge clk);
    chk({5'h0, irq, g1, wake}, {5'h0, e});
  endtask
  task automatic t_zero;
    rreg(status_offset, 8'h00);
    rreg(12'h000, 8'h00);
    wreg(select_offset, 8'hf1);
    lv3 <= 4'he;
    wk(3'h1);
    lv3 <= 4'hf;
    wk(3'h0);
    $display("t_zero done");
  endtask
  task automatic t_ref;
    wreg(select_offset, 8'hf3);
    pacc(1'b0, 1'b1, 4'h1);
    rreg(status_offset, 8'h08);
    lv3 <= 4'h1;
    wk(3'h0);
    lv3 <= 4'h3;
    wk(3'h1);
    pacc(1'b0, 1'b0, 4'h3);
    rreg(status_offset, 8'h04);
    wk(3'h0);
    $display("t_ref done");
  endtask
  task automatic t_clear;
    wreg(status_offset, 8'h10);
    rreg(status_offset, 8'h10);
    lv3 <= 4'h2;
    wk(3'h3);
    wreg(status_offset, 8'h00);
    wk(3'h1);
    mode <= 1'b1;
    wk(3'h3);
    mode <= 1'b0;
    rreg(irq_status_offset, 8'h01);
    wreg(irq_mask_offset, 8'h01);
    wk(3'h5);
    lv3 <= 4'h3;
    repeat (3) @(posedge clk);
    wreg(irq_status_offset, 8'h01);
    wk(3'h0);
    $display("t_clear done");
  endtask
  task automatic t_port2;
    wreg(port2_select_offset, 8'hf1);
    pacc(1'b1, 1'b1, 4'h1);
    rreg(status_offset, 8'h02);
    lv2 <= 4'he;
    wk(3'h1);
    $display("t_port2 done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    {sys_rst, wr, rd, mode, addr, wdata, a3, a2} = '0;
    sys_rst = 1'b1;
    lv3 = 4'hf;
    lv2 = 4'hf;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_zero();
    t_ref();
    t_clear();
    t_port2();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
